// >>> verilog/adm_mode_regs.sv
// mode control register bank with attenuation ramp, top of the block
`timescale 1ns/1ns
`default_nettype none
module adm_mode_regs #(
  parameter logic [4:0] DEVICE_ID = 5'h0B // arbitrary value
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SER_CLK,
  input wire logic SER_LATCH_N,
  input wire logic SER_DIN,
  output logic SER_DOUT,
  output logic SER_DOUT_OE,
  input wire logic SAMPLE_WORD_CLOCK,
  input wire logic LEFT_ZERO_FLAG,
  input wire logic RIGHT_ZERO_FLAG,
  output logic [2:0] AUDIO_FORMAT_SELECT,
  output logic DEEMPH_ENABLE,
  output logic [1:0] DEEMPH_RATE_SELECT,
  output logic [1:0] FIR_PERF_SELECT,
  output logic [7:0] LEFT_APPLIED_CODE,
  output logic [7:0] RIGHT_APPLIED_CODE,
  output logic [7:0] LEFT_ATTEN_HALF_DB,
  output logic [7:0] RIGHT_ATTEN_HALF_DB,
  output logic LEFT_SILENT,
  output logic RIGHT_SILENT,
  output logic [7:0] OUTPUT_FILTER_CTRL,
  output logic [7:0] SYSTEM_MODE_CTRL,
  output logic [7:0] ZERO_OUTPUT_CTRL
);
  adm_link_if lnk ();

  logic tg_s1_r;
  logic tg_s2_r;
  logic tg_s3_r;
  logic host_evt;
  logic host_write;
  logic [6:0] host_idx;
  logic [7:0] host_data;
  logic [7:0] left_level_code_r;
  logic [7:0] right_level_code_r;
  logic [7:0] fmt_ctrl_r;
  logic [7:0] filt_ctrl_r;
  logic [7:0] sys_ctrl_r;
  logic [7:0] zout_ctrl_r;
  logic [7:0] left_target_r;
  logic [7:0] right_target_r;
  logic [7:0] left_goal;
  logic [7:0] right_goal;
  logic [7:0] left_applied_r;
  logic [7:0] right_applied_r;
  logic sw_s1_r;
  logic sw_s2_r;
  logic sw_s3_r;
  logic sw_edge;
  logic [2:0] div_cnt_r;
  logic [2:0] div_cnt_nxt;
  logic [1:0] level_step_rate;
  logic step_tick;
  logic level_load_enable;
  logic soft_mute;
  logic stream_mode;

  ////////////////////////////////////////////////////////////////////////////
  // serial port in the link clock domain

  adm_serial_port u_port (
    .ser_clk(SER_CLK),
    .rst(RST),
    .latch_n(SER_LATCH_N),
    .din(SER_DIN),
    .dout(SER_DOUT),
    .dout_oe(SER_DOUT_OE),
    .lnk(lnk.port)
  );

  assign lnk.cfg_bytes = {zout_ctrl_r, sys_ctrl_r, filt_ctrl_r, fmt_ctrl_r,
                          right_level_code_r, left_level_code_r};
  assign lnk.zero_raw = {RIGHT_ZERO_FLAG, LEFT_ZERO_FLAG};
  assign lnk.dev_id = DEVICE_ID;

  ////////////////////////////////////////////////////////////////////////////
  // word arrival: toggle synchroniser, word itself is held stable meanwhile

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tg_s1_r <= 1'b0;
      tg_s2_r <= 1'b0;
      tg_s3_r <= 1'b0;
    end else begin
      tg_s1_r <= lnk.word_tgl;
      tg_s2_r <= tg_s1_r;
      tg_s3_r <= tg_s2_r;
    end
  end

  // frames must be spaced by a few core cycles so the held word is not replaced
  assign host_evt = tg_s2_r ^ tg_s3_r;
  assign host_write = host_evt && !lnk.word[adm_pkg::RW_BIT];
  assign host_idx = lnk.word[adm_pkg::IDX_MSB:adm_pkg::IDX_LSB];
  assign host_data = lnk.word[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // register file

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      left_level_code_r <= adm_pkg::LEVEL_RST;
      right_level_code_r <= adm_pkg::LEVEL_RST;
      fmt_ctrl_r <= adm_pkg::FMT_RST;
      filt_ctrl_r <= adm_pkg::FILT_RST;
      sys_ctrl_r <= adm_pkg::SYS_RST;
      zout_ctrl_r <= adm_pkg::ZOUT_RST;
    end else if (host_write) begin
      case (host_idx)
        adm_pkg::IDX_LEFT: left_level_code_r <= host_data;
        adm_pkg::IDX_RIGHT: right_level_code_r <= host_data;
        adm_pkg::IDX_FMT: fmt_ctrl_r <= host_data;
        adm_pkg::IDX_FILT: filt_ctrl_r <= host_data;
        adm_pkg::IDX_SYS: sys_ctrl_r <= host_data & adm_pkg::SYS_MASK;
        adm_pkg::IDX_ZOUT: zout_ctrl_r <= host_data & adm_pkg::ZOUT_MASK;
        default: ; // read-only and unmapped indexes keep their contents
      endcase
    end
  end

  assign level_load_enable = fmt_ctrl_r[adm_pkg::LOAD_EN_BIT];
  assign soft_mute = fmt_ctrl_r[adm_pkg::MUTE_BIT];
  assign level_step_rate = filt_ctrl_r[adm_pkg::ATS_MSB:adm_pkg::ATS_LSB];
  assign stream_mode = sys_ctrl_r[adm_pkg::STREAM_BIT];

  // the register keeps what was written; only the target follows the load gate
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      left_target_r <= adm_pkg::LEVEL_RST;
      right_target_r <= adm_pkg::LEVEL_RST;
    end else if (host_write && level_load_enable) begin
      if (host_idx == adm_pkg::IDX_LEFT) begin
        left_target_r <= host_data;
      end
      if (host_idx == adm_pkg::IDX_RIGHT) begin
        right_target_r <= host_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // step timing from the sample word clock pin

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sw_s1_r <= 1'b0;
      sw_s2_r <= 1'b0;
      sw_s3_r <= 1'b0;
    end else begin
      sw_s1_r <= SAMPLE_WORD_CLOCK;
      sw_s2_r <= sw_s1_r;
      sw_s3_r <= sw_s2_r;
    end
  end

  assign sw_edge = sw_s2_r && !sw_s3_r;

  function automatic logic [2:0] rate_last(input logic [1:0] rate);
    logic [2:0] m;
    m = 3'h0;
    case (rate)
      2'h0: m = 3'h0;
      2'h1: m = 3'h1;
      2'h2: m = 3'h3;
      2'h3: m = 3'h7;
      default: m = 3'h0;
    endcase
    return m;
  endfunction

  assign step_tick = sw_edge && (div_cnt_r >= rate_last(level_step_rate));

  always_comb begin
    div_cnt_nxt = div_cnt_r;
    if (step_tick) begin
      div_cnt_nxt = adm_pkg::DIV_RST;
    end else if (sw_edge) begin
      div_cnt_nxt = div_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      div_cnt_r <= adm_pkg::DIV_RST;
    end else begin
      div_cnt_r <= div_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // level ramp toward the target, or toward silence while muted

  function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] goal);
    logic [7:0] n;
    n = cur;
    if (cur < goal) begin
      n = cur + 8'h01;
    end else if (cur > goal) begin
      n = cur - 8'h01;
    end
    return n;
  endfunction

  function automatic logic is_silent(input logic [7:0] code);
    return code <= adm_pkg::SILENT_MAX;
  endfunction

  function automatic logic [7:0] atten_half_db(input logic [7:0] code);
    return adm_pkg::LEVEL_RST - code;
  endfunction

  // mute walks from the applied code one step per tick down to zero
  assign left_goal = soft_mute ? adm_pkg::MUTE_LEVEL : left_target_r;
  assign right_goal = soft_mute ? adm_pkg::MUTE_LEVEL : right_target_r;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      left_applied_r <= adm_pkg::LEVEL_RST;
      right_applied_r <= adm_pkg::LEVEL_RST;
    end else if (step_tick) begin
      left_applied_r <= step_toward(left_applied_r, left_goal);
      right_applied_r <= step_toward(right_applied_r, right_goal);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      LEFT_APPLIED_CODE <= adm_pkg::LEVEL_RST;
      RIGHT_APPLIED_CODE <= adm_pkg::LEVEL_RST;
      LEFT_ATTEN_HALF_DB <= 8'h00;
      RIGHT_ATTEN_HALF_DB <= 8'h00;
      LEFT_SILENT <= 1'b0;
      RIGHT_SILENT <= 1'b0;
    end else begin
      LEFT_APPLIED_CODE <= left_applied_r;
      RIGHT_APPLIED_CODE <= right_applied_r;
      LEFT_ATTEN_HALF_DB <= atten_half_db(left_applied_r);
      RIGHT_ATTEN_HALF_DB <= atten_half_db(right_applied_r);
      LEFT_SILENT <= is_silent(left_applied_r);
      RIGHT_SILENT <= is_silent(right_applied_r);
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      AUDIO_FORMAT_SELECT <= adm_pkg::FMT_RST[adm_pkg::FMT_MSB:adm_pkg::FMT_LSB];
      DEEMPH_ENABLE <= 1'b0;
      DEEMPH_RATE_SELECT <= 2'h0;
      FIR_PERF_SELECT <= 2'h0;
      OUTPUT_FILTER_CTRL <= adm_pkg::FILT_RST;
      SYSTEM_MODE_CTRL <= adm_pkg::SYS_RST;
      ZERO_OUTPUT_CTRL <= adm_pkg::ZOUT_RST;
    end else begin
      AUDIO_FORMAT_SELECT <= fmt_ctrl_r[adm_pkg::FMT_MSB:adm_pkg::FMT_LSB];
      // in stream mode the rate field drives the FIR filter, not de-emphasis
      DEEMPH_ENABLE <= fmt_ctrl_r[adm_pkg::DME_BIT] && !stream_mode;
      DEEMPH_RATE_SELECT <= stream_mode ? 2'h0 :
                            fmt_ctrl_r[adm_pkg::DMF_MSB:adm_pkg::DMF_LSB];
      FIR_PERF_SELECT <= stream_mode ?
                         fmt_ctrl_r[adm_pkg::DMF_MSB:adm_pkg::DMF_LSB] : 2'h0;
      OUTPUT_FILTER_CTRL <= filt_ctrl_r;
      SYSTEM_MODE_CTRL <= sys_ctrl_r;
      ZERO_OUTPUT_CTRL <= zout_ctrl_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  a_write_lands_left: assert property (
    (host_write && host_idx == adm_pkg::IDX_LEFT) |=> left_level_code_r == $past(host_data))
    else $error("left level write did not land");

  a_read_only_kept: assert property (
    (host_write && (host_idx == adm_pkg::IDX_ZFLAG || host_idx == adm_pkg::IDX_ID))
    |=> $stable(lnk.cfg_bytes))
    else $error("write to read-only index changed registers");

  a_read_no_change: assert property (
    (host_evt && lnk.word[adm_pkg::RW_BIT]) |=> $stable(lnk.cfg_bytes))
    else $error("read altered a register");

  a_load_gate_held: assert property (
    (host_write && !level_load_enable && host_idx == adm_pkg::IDX_LEFT)
    |=> $stable(left_target_r))
    else $error("level target moved with load disabled");

  a_reset_defaults: assert property (
    $fell(RST) |-> (left_level_code_r == 8'hFF && fmt_ctrl_r == 8'h50
                    && left_applied_r == 8'hFF))
    else $error("reset values wrong");

  a_level_only_on_tick: assert property (
    !step_tick |=> $stable(left_applied_r))
    else $error("applied level moved without a step tick");

  a_mute_steps_down: assert property (
    (step_tick && soft_mute && left_applied_r != 8'h00)
    |=> left_applied_r == $past(left_applied_r) - 8'h01)
    else $error("soft mute did not step down by one");

  a_rate_divide: assert property (
    (step_tick && level_step_rate == 2'h3) |-> div_cnt_r == 3'h7)
    else $error("rate divider ticked before the eighth edge");

  // a lowered rate may leave the count above its new end, so only the reached end is checked
  a_tick_at_count: assert property (
    (sw_edge && div_cnt_r == rate_last(level_step_rate)) |-> step_tick)
    else $error("no step tick at divider count");

  a_gain_and_silent: assert property (
    1'b1 |=> (LEFT_ATTEN_HALF_DB == 8'hFF - $past(left_applied_r)
              && LEFT_SILENT == ($past(left_applied_r) < 8'h0F)) ##1 1'b1)
    else $error("gain or silence output wrong");

  a_deemph_route: assert property (
    (stream_mode && $stable(fmt_ctrl_r)) |=> (!DEEMPH_ENABLE
      && FIR_PERF_SELECT == $past(fmt_ctrl_r[adm_pkg::DMF_MSB:adm_pkg::DMF_LSB])))
    else $error("de-emphasis routing wrong in stream mode");

  a_mute_bit_write: assert property (
    (host_write && host_idx == adm_pkg::IDX_FMT) |=> soft_mute == $past(host_data[0]))
    else $error("mute bit did not follow the write");

  c_left_write: cover property (host_write && host_idx == adm_pkg::IDX_LEFT && level_load_enable);
  c_read_word: cover property (host_evt && lnk.word[adm_pkg::RW_BIT]);
  c_mute_reached: cover property (soft_mute && step_tick && left_applied_r == 8'h01);
endmodule
`default_nettype wire

// >>> verilog/adm_pkg.sv
// constants shared by the mode register bank and its serial control port
package adm_pkg;
  localparam int WORD_BITS = 16;
  localparam int RW_BIT = 15;
  localparam int IDX_MSB = 14;
  localparam int IDX_LSB = 8;
  localparam logic [3:0] BIT_IDX_B8 = 4'h7;
  localparam logic [3:0] BIT_IDX_LAST = 4'hF;

  localparam logic [6:0] IDX_LEFT = 7'h10;
  localparam logic [6:0] IDX_RIGHT = 7'h11;
  localparam logic [6:0] IDX_FMT = 7'h12;
  localparam logic [6:0] IDX_FILT = 7'h13;
  localparam logic [6:0] IDX_SYS = 7'h14;
  localparam logic [6:0] IDX_ZOUT = 7'h15;
  localparam logic [6:0] IDX_ZFLAG = 7'h16;
  localparam logic [6:0] IDX_ID = 7'h17;

  localparam logic [7:0] LEVEL_RST = 8'hFF;
  localparam logic [7:0] FMT_RST = 8'h50;
  localparam logic [7:0] FILT_RST = 8'h00;
  localparam logic [7:0] SYS_RST = 8'h00;
  localparam logic [7:0] ZOUT_RST = 8'h01;
  localparam logic [7:0] SYS_MASK = 8'h7F;
  localparam logic [7:0] ZOUT_MASK = 8'h07;

  localparam int LOAD_EN_BIT = 7;
  localparam int FMT_MSB = 6;
  localparam int FMT_LSB = 4;
  localparam int DMF_MSB = 3;
  localparam int DMF_LSB = 2;
  localparam int DME_BIT = 1;
  localparam int MUTE_BIT = 0;
  localparam int ATS_MSB = 6;
  localparam int ATS_LSB = 5;
  localparam int STREAM_BIT = 5;

  localparam logic [7:0] SILENT_MAX = 8'h0E;
  localparam logic [7:0] MUTE_LEVEL = 8'h00;
  localparam logic [2:0] DIV_RST = 3'h0;
endpackage

// >>> verilog/adm_link_if.sv
// carrier between the serial control port and the register core
`timescale 1ns/1ns
`default_nettype none
interface adm_link_if;
  logic [15:0] word;
  logic word_tgl;
  logic [47:0] cfg_bytes;
  logic [1:0] zero_raw;
  logic [4:0] dev_id;
  modport port (output word, output word_tgl, input cfg_bytes, input zero_raw, input dev_id);
  modport core (input word, input word_tgl, output cfg_bytes, output zero_raw, output dev_id);
endinterface
`default_nettype wire

// >>> verilog/adm_serial_port.sv
// serial control port shifter, runs on the host's serial clock
`timescale 1ns/1ns
`default_nettype none
module adm_serial_port (
  input wire logic ser_clk,
  input wire logic rst,
  input wire logic latch_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  adm_link_if.port lnk
);
  logic frame_rst;
  logic [3:0] cnt_r;
  logic [14:0] sr_r;
  logic rd_r;
  logic [6:0] rd_sh_r;
  logic [1:0] zf_s1_r;
  logic [1:0] zf_s2_r;
  logic [7:0] rd_byte;

  // latch high aborts any partial frame; the serial clock may be stopped then
  assign frame_rst = rst | latch_n;

  function automatic logic [7:0] read_byte(input logic [6:0] idx, input logic [47:0] cfg,
                                           input logic [1:0] zf, input logic [4:0] id);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      adm_pkg::IDX_LEFT: b = cfg[7:0];
      adm_pkg::IDX_RIGHT: b = cfg[15:8];
      adm_pkg::IDX_FMT: b = cfg[23:16];
      adm_pkg::IDX_FILT: b = cfg[31:24];
      adm_pkg::IDX_SYS: b = cfg[39:32];
      adm_pkg::IDX_ZOUT: b = cfg[47:40];
      adm_pkg::IDX_ZFLAG: b = {6'h00, zf};
      adm_pkg::IDX_ID: b = {3'h0, id};
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // config bytes only change a few core cycles after the last bit of the write that set them, so they are
  // quasi-static when sampled here; the zero flags are live and resynchronised
  assign rd_byte = read_byte({sr_r[5:0], din}, lnk.cfg_bytes, zf_s2_r, lnk.dev_id);

  always_ff @(posedge ser_clk or posedge rst) begin
    if (rst) begin
      zf_s1_r <= 2'h0;
      zf_s2_r <= 2'h0;
    end else begin
      zf_s1_r <= lnk.zero_raw;
      zf_s2_r <= zf_s1_r;
    end
  end

  always_ff @(posedge ser_clk or posedge frame_rst) begin
    if (frame_rst) begin
      cnt_r <= 4'h0;
      sr_r <= 15'h0000;
      rd_r <= 1'b0;
      rd_sh_r <= 7'h00;
      dout <= 1'b0;
      dout_oe <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      sr_r <= {sr_r[13:0], din};
      if (cnt_r == adm_pkg::BIT_IDX_B8) begin
        rd_r <= sr_r[6];
        if (sr_r[6]) begin
          dout <= rd_byte[7];
          rd_sh_r <= rd_byte[6:0];
          dout_oe <= 1'b1;
        end
      end else if (rd_r) begin
        dout <= rd_sh_r[6];
        rd_sh_r <= {rd_sh_r[5:0], 1'b0};
      end
      if (cnt_r == adm_pkg::BIT_IDX_LAST) begin
        dout_oe <= 1'b0;
        rd_r <= 1'b0;
      end
    end
  end

  // whole word held stable and announced by a toggle for the core domain
  always_ff @(posedge ser_clk or posedge rst) begin
    if (rst) begin
      lnk.word <= 16'h0000;
      lnk.word_tgl <= 1'b0;
    end else if (!latch_n && cnt_r == adm_pkg::BIT_IDX_LAST) begin
      lnk.word <= {sr_r, din};
      lnk.word_tgl <= ~lnk.word_tgl;
    end
  end

  a_read_drives_out: assert property (@(posedge ser_clk) disable iff (frame_rst)
    (cnt_r == adm_pkg::BIT_IDX_B8 && sr_r[6]) |=> dout_oe [*7])
    else $error("read data not driven for the data bits");
endmodule
`default_nettype wire

// >>> tb/adm_host_model.sv
// host controller model that drives the serial control port frame by frame
`timescale 1ns/1ns
`default_nettype none
module adm_host_model #(
  parameter int HALF_NS = 40,
  parameter int PHASE_NS = 7
) (
  output logic ser_clk,
  output logic latch_n,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe,
  output logic [7:0] rd_data,
  output logic rd_tgl
);
  initial begin
    ser_clk = 1'b0;
    latch_n = 1'b1;
    din = 1'b0;
    rd_data = 8'h00;
    rd_tgl = 1'b0;
  end

  // serial clock stands low outside frames; phase offset keeps it unrelated to the core clock
  task automatic xfer(input logic [15:0] w);
    logic [7:0] sh;
    sh = 8'h00;
    #(PHASE_NS);
    latch_n = 1'b0;
    #(HALF_NS);
    for (int i = 15; i >= 0; i--) begin
      din = w[i];
      #(HALF_NS);
      if (i < 8) begin
        sh = {sh[6:0], dout & dout_oe};
      end
      ser_clk = 1'b1;
      #(HALF_NS);
      ser_clk = 1'b0;
    end
    #(HALF_NS);
    latch_n = 1'b1;
    // released line shows the inverse so a stale bit is never mistaken for data
    din = ~din;
    if (w[15]) begin
      rd_data = sh;
      rd_tgl = ~rd_tgl;
    end
    // gap covers the core-side update latency and the minimum frame spacing
    #(5 * HALF_NS);
  endtask
endmodule
`default_nettype wire

// >>> tb/audio_dac_mode_registers_tb_top.sv
// self-checking bench for the mode control register bank
`timescale 1ns/1ns
`default_nettype none
module audio_dac_mode_registers_tb_top;
  localparam logic [4:0] DEV_ID = 5'h0B; // arbitrary value
  logic core_clk, rst, ser_clk, latch_n, din, dout, dout_oe, swc, zl, zr, rd_tgl;
  logic dme_o, lsil, rsil;
  logic [1:0] dmf_o, fir_o, zf;
  logic [2:0] fmt_o;
  logic [7:0] lcode, rcode, latt, ratt, filt_o, rd_data, v, sys_o, zout_o;
  logic [7:0] exp_q[$];
  int n_errors, n_checks;

  adm_mode_regs #(.DEVICE_ID(DEV_ID)) u_dut (
    .CORE_CLK(core_clk), .RST(rst), .SER_CLK(ser_clk), .SER_LATCH_N(latch_n),
    .SER_DIN(din), .SER_DOUT(dout), .SER_DOUT_OE(dout_oe), .SAMPLE_WORD_CLOCK(swc),
    .LEFT_ZERO_FLAG(zl), .RIGHT_ZERO_FLAG(zr), .AUDIO_FORMAT_SELECT(fmt_o),
    .DEEMPH_ENABLE(dme_o), .DEEMPH_RATE_SELECT(dmf_o), .FIR_PERF_SELECT(fir_o),
    .LEFT_APPLIED_CODE(lcode), .RIGHT_APPLIED_CODE(rcode), .LEFT_ATTEN_HALF_DB(latt),
    .RIGHT_ATTEN_HALF_DB(ratt), .LEFT_SILENT(lsil), .RIGHT_SILENT(rsil),
    .OUTPUT_FILTER_CTRL(filt_o), .SYSTEM_MODE_CTRL(sys_o), .ZERO_OUTPUT_CTRL(zout_o)
  );

  adm_host_model u_host (
    .ser_clk(ser_clk), .latch_n(latch_n), .din(din), .dout(dout), .dout_oe(dout_oe),
    .rd_data(rd_data), .rd_tgl(rd_tgl)
  );

  always #5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    u_host.xfer({1'b0, idx, d});
  endtask

  task automatic rd(input logic [6:0] idx, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.xfer({1'b1, idx, 8'h00});
  endtask

  // four core cycles each level keeps every edge visible through the two-flop sync
  task automatic sample_edges(input int n);
    repeat (n) begin
      swc <= 1'b1;
      repeat (4) @(posedge core_clk);
      swc <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    repeat (6) @(posedge core_clk);
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    wait (rst === 1'b0);
    forever begin
      @(rd_tgl);
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("wrong value at %0t: read with no expectation", $time);
      end else begin
        chk(rd_data, exp_q.pop_front(), "readback");
      end
    end
  end

  initial begin
    #500000;
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    n_errors = 0;
    n_checks = 0;
    core_clk = 1'b0;
    rst = 1'b1;
    swc = 1'b0;
    zl = 1'b0;
    zr = 1'b0;
    void'($urandom(32'h775204DA));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk(lcode, 8'hFF, "left code");
    chk(latt, 8'h00, "left atten");
    chk({5'h00, fmt_o}, 8'h05, "format");
    chk({6'h00, dmf_o}, 8'h00, "rate");
    chk({7'h00, dme_o}, 8'h00, "deemph");
    chk(zout_o, 8'h01, "zero out reset");
    rd(adm_pkg::IDX_LEFT, 8'hFF);
    rd(adm_pkg::IDX_RIGHT, 8'hFF);
    rd(adm_pkg::IDX_FMT, 8'h50);
    zf = 2'($urandom);
    @(posedge core_clk);
    zl <= zf[0];
    zr <= zf[1];
    wr(adm_pkg::IDX_ZFLAG, 8'hFF);
    wr(adm_pkg::IDX_ID, 8'hFF);
    rd(adm_pkg::IDX_ZFLAG, {6'h00, zf});
    rd(adm_pkg::IDX_ID, {3'h0, DEV_ID});
    wr(7'h30, 8'hA5);
    rd(7'h30, 8'h00);
    v = 8'($urandom) & 8'h9F;
    wr(adm_pkg::IDX_FILT, v);
    rd(adm_pkg::IDX_FILT, v);
    chk(filt_o, v, "filter reg");
    for (int f = 0; f < 8; f++) begin
      v = {1'b0, 3'(f), 2'($urandom), 1'($urandom), 1'b0};
      wr(adm_pkg::IDX_FMT, v);
      rd(adm_pkg::IDX_FMT, v);
      chk({5'h00, fmt_o}, {5'h00, v[6:4]}, "format");
      chk({6'h00, dmf_o}, {6'h00, v[3:2]}, "rate");
      chk({7'h00, dme_o}, {7'h00, v[1]}, "deemph");
    end
    v = 8'h5E;
    wr(adm_pkg::IDX_FMT, v);
    // top bit is reserved and must come out as zero on the system output
    wr(adm_pkg::IDX_SYS, 8'hA0);
    chk(sys_o, 8'h20, "system reg");
    chk({6'h00, fir_o}, {6'h00, v[3:2]}, "fir perf");
    chk({6'h00, dmf_o}, 8'h00, "rate in stream");
    chk({7'h00, dme_o}, 8'h00, "deemph in stream");
    wr(adm_pkg::IDX_SYS, 8'h00);
    // load enable off: register takes the value but the level must not move
    wr(adm_pkg::IDX_FMT, 8'h50);
    wr(adm_pkg::IDX_LEFT, 8'h80);
    rd(adm_pkg::IDX_LEFT, 8'h80);
    sample_edges(4);
    chk(lcode, 8'hFF, "gated level");
    wr(adm_pkg::IDX_FMT, 8'hD0);
    rd(adm_pkg::IDX_FMT, 8'hD0);
    wr(adm_pkg::IDX_LEFT, 8'hF0);
    wr(adm_pkg::IDX_RIGHT, 8'h0F);
    sample_edges(5);
    chk(lcode, 8'hFA, "ramp rate 1");
    chk(latt, 8'h05, "left atten");
    // 16 edges at divide-by-8 give two steps whatever the divider phase
    wr(adm_pkg::IDX_FILT, 8'h60);
    sample_edges(16);
    chk(lcode, 8'hF8, "ramp rate 8");
    wr(adm_pkg::IDX_FILT, 8'h20);
    sample_edges(4);
    chk(lcode, 8'hF6, "ramp rate 2");
    wr(adm_pkg::IDX_FILT, 8'h40);
    sample_edges(8);
    chk(lcode, 8'hF4, "ramp rate 4");
    wr(adm_pkg::IDX_FILT, 8'h00);
    sample_edges(250);
    chk(lcode, 8'hF0, "left target");
    chk(rcode, 8'h0F, "right target");
    chk({7'h00, rsil}, 8'h00, "silent at 15");
    wr(adm_pkg::IDX_RIGHT, 8'h0E);
    sample_edges(1);
    chk({7'h00, rsil}, 8'h01, "silent at 14");
    chk(ratt, 8'hF1, "right atten");
    wr(adm_pkg::IDX_FMT, 8'hD1);
    sample_edges(100);
    chk(lcode, 8'h8C, "mute ramp");
    sample_edges(150);
    chk(lcode, 8'h00, "muted");
    chk({7'h00, lsil}, 8'h01, "muted silent");
    repeat (10) @(posedge core_clk);
    chk(8'(exp_q.size()), 8'h00, "pending reads");
    finish_test();
  end
endmodule
`default_nettype wire
